// file: hw/pci_controller_status_flags.sv
// apb status, mask and control bank of the pci controller event flags
//
// Function
// - host mode wake event sets sticky bit 10
// - burst over eight doublewords sets bit 9
// - downward address burst sets bit 8
// - non incrementing burst sets bit 7
// - parity error always latches bit 5
// - system error always latches bit 4
// - bus timeout on own master cycle sets bit 3
// - ignore bus timeouts when not master
// - bit 1 shows outbound write busy
// - hold write error until write ends
// - bit 0 set when config load completes
// - retry target access until ready and done
// - interrupt only for enabled latched flags
`timescale 1ns/1ns
`include "pci_ctl_status_regs.svh"

module pci_controller_status_flags #(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned BLEN_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic              pme_n,
  input  wire logic              perr_n,
  input  wire logic              serr_n,
  input  wire logic              dma_burst_valid,
  input  wire logic [BLEN_W-1:0] dma_burst_len,
  input  wire logic              dma_burst_down,
  input  wire logic              dma_burst_fixed,
  input  wire logic              ibus_timeout,
  input  wire logic              ibus_own_master,
  input  wire logic              wr_start,
  input  wire logic              wr_end,
  input  wire logic              wr_error,
  input  wire logic              cfg_load_end,
  output logic                   target_retry
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change counted when stages two and three agree
  // the stages carry the asserted sense, so their reset value is the idle level
  // and no false event follows reset
  logic [2:0] pme_s_r;
  logic [2:0] perr_s_r;
  logic [2:0] serr_s_r;
  logic       pme_lvl_r;
  logic       perr_lvl_r;
  logic       serr_lvl_r;

  // wake pin stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pme_s_r <= `SYNC_RESET;
    end else begin
      pme_s_r <= {pme_s_r[1:0], ~pme_n};
    end
  end

  // parity error pin stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_s_r <= `SYNC_RESET;
    end else begin
      perr_s_r <= {perr_s_r[1:0], ~perr_n};
    end
  end

  // system error pin stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serr_s_r <= `SYNC_RESET;
    end else begin
      serr_s_r <= {serr_s_r[1:0], ~serr_n};
    end
  end

  // filtered levels only move when the two late stages agree; a glitch that
  // reaches only one late stage is dropped
  wire pme_agree  = (pme_s_r[1] == pme_s_r[2]);
  wire perr_agree = (perr_s_r[1] == perr_s_r[2]);
  wire serr_agree = (serr_s_r[1] == serr_s_r[2]);

  // wake level filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pme_lvl_r <= 1'b0;
    end else if (pme_agree) begin
      pme_lvl_r <= pme_s_r[2];
    end
  end

  // parity error level filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_lvl_r <= 1'b0;
    end else if (perr_agree) begin
      perr_lvl_r <= perr_s_r[2];
    end
  end

  // system error level filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serr_lvl_r <= 1'b0;
    end else if (serr_agree) begin
      serr_lvl_r <= serr_s_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, so pready is a constant-high flop after reset
  // register map: status at the base, interrupt mask one word up, control above;
  // control bit 0 is target ready, bit 1 host mode; any other address is unmapped
  // and answers with an error and zero data
  logic                          pready_r;
  logic                          pslverr_r;
  pci_ctl_status_pkg::word_type  prdata_r;
  pci_ctl_status_pkg::word_type  stat_r;
  pci_ctl_status_pkg::word_type  mask_r;
  pci_ctl_status_pkg::word_type  ctrl_r;
  pci_ctl_status_pkg::wr_state_type wr_state_r;
  pci_ctl_status_pkg::wr_state_type wr_state_nxt;
  logic                          wr_err_held_r;
  logic                          cfg_done_r;
  logic                          irq_r;
  logic                          retry_r;

  // full address compare, so no alias reaches a register
  wire access   = psel && penable;
  wire wr_acc   = access && pwrite;
  wire hit_stat = (paddr == ADDR_W'(`STAT_OFFSET));
  wire hit_mask = (paddr == ADDR_W'(`MASK_OFFSET));
  wire hit_ctrl = (paddr == ADDR_W'(`CTRL_OFFSET));
  wire unmapped = !(hit_stat || hit_mask || hit_ctrl);

  // expand byte strobes to a bit mask; lanes not strobed are left alone
  function automatic pci_ctl_status_pkg::word_type lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask

  // write data with the unstrobed lanes forced low
  wire [31:0] wmask = pwdata & lane_mask(pstrb);

  ////////////////////////////////////////////////////////////////////////////
  // event detection
  // host mode gates the wake pin; in satellite mode the pin belongs to the host
  wire host_mode   = ctrl_r[`BIT_HOST_MODE];
  wire ev_wake     = pme_lvl_r && host_mode;
  // burst shape checks, looked at only while the dma reports a burst
  wire ev_long     = dma_burst_valid && (dma_burst_len > BLEN_W'(`MAX_BURST_DW));
  wire ev_down     = dma_burst_valid && dma_burst_down;
  wire ev_fixed    = dma_burst_valid && dma_burst_fixed;
  // bus pins latch whether or not this controller is on the bus
  wire ev_parity   = perr_lvl_r;
  wire ev_syserr   = serr_lvl_r;
  // own-master timeouts only; a busy write parks its error until it ends
  wire ev_tmo_now  = ibus_timeout && ibus_own_master;
  wire ev_wr_err   = (wr_state_r == pci_ctl_status_pkg::WR_DONE) && wr_err_held_r;
  wire ev_bus_err  = ev_tmo_now || ev_wr_err;

  // one set request per event at its field position
  wire [31:0] set_bits = (32'(ev_wake)    << `BIT_WAKE)
                       | (32'(ev_long)    << `BIT_LONG_BURST)
                       | (32'(ev_down)    << `BIT_DEC_BURST)
                       | (32'(ev_fixed)   << `BIT_FIX_BURST)
                       | (32'(ev_parity)  << `BIT_PARITY)
                       | (32'(ev_syserr)  << `BIT_SYSERR)
                       | (32'(ev_bus_err) << `BIT_BUS_ERR);

  // write-one-to-clear; a set in the same cycle wins over the clear, so an event
  // that lands on the clearing write is seen at the next read
  wire [31:0] clr_bits = (wr_acc && hit_stat) ? wmask : `ZERO_WORD;
  wire [31:0] stat_nxt = ((stat_r & ~clr_bits) | set_bits) & `STICKY_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // outbound write tracker
  // one write is tracked at a time; a start while busy or done is not counted
  always_comb begin
    wr_state_nxt = wr_state_r;
    unique case (wr_state_r)
      pci_ctl_status_pkg::WR_IDLE: begin
        if (wr_start) wr_state_nxt = pci_ctl_status_pkg::WR_BUSY;
      end
      pci_ctl_status_pkg::WR_BUSY: begin
        if (wr_end) wr_state_nxt = pci_ctl_status_pkg::WR_DONE;
      end
      // done lasts one cycle, the window in which a held error is posted
      pci_ctl_status_pkg::WR_DONE: begin
        wr_state_nxt = pci_ctl_status_pkg::WR_IDLE;
      end
      // the unused code drops back to idle
      default: begin
        wr_state_nxt = pci_ctl_status_pkg::WR_IDLE;
      end
    endcase
  end

  // busy is live, not latched: it reads back the tracker state
  wire wr_busy = (wr_state_r == pci_ctl_status_pkg::WR_BUSY);

  // tracker state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_state_r <= pci_ctl_status_pkg::WR_IDLE;
    end else begin
      wr_state_r <= wr_state_nxt;
    end
  end

  // error collected while busy, released one cycle after the end; cleared in idle
  // so an error of an earlier write is never posted against a later one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_err_held_r <= 1'b0;
    end else if (wr_state_r == pci_ctl_status_pkg::WR_IDLE) begin
      wr_err_held_r <= 1'b0;
    end else if (wr_busy && wr_error) begin
      wr_err_held_r <= 1'b1;
    end
  end

  // load done is sticky until reset; also fires with no memory fitted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_done_r <= 1'b0;
    end else if (cfg_load_end) begin
      cfg_done_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags load every cycle, so no event is lost to a pending clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= `ZERO_WORD;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // interrupt enables share the status layout; byte lanes follow pstrb
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= `ZERO_WORD;
    end else if (wr_acc && hit_mask) begin
      mask_r <= ((mask_r & ~lane_mask(pstrb)) | wmask) & `STICKY_MASK;
    end
  end

  // control: target ready and host mode; all other bits read back zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr_acc && hit_ctrl) begin
      ctrl_r <= ((ctrl_r & ~lane_mask(pstrb)) | wmask) & `CTRL_MASK;
    end
  end

  // live read-only bits joined onto the sticky flags
  // busy and done ignore writes; software cannot clear them
  wire [31:0] stat_view = stat_r
                        | (32'(wr_busy) << `BIT_WR_BUSY)
                        | (32'(cfg_done_r) << `BIT_CFG_DONE);

  // read selection; unmapped reads return zero
  wire [31:0] rd_mux = hit_stat ? stat_view
                     : hit_mask ? mask_r
                     : hit_ctrl ? ctrl_r
                     : `ZERO_WORD;

  // read data registered in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= `ZERO_WORD;
    end else begin
      prdata_r <= (psel && !pwrite) ? rd_mux : `ZERO_WORD;
    end
  end

  // no wait states: ready rises at the first edge after reset and stays up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
    end
  end

  // error flagged in setup for an unmapped address, shown in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= psel && !penable && unmapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt follows the next status value so it rises with the flag; a masked
  // flag still latches, and enabling it later raises the interrupt one cycle after the mask write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  // retry until software marks the target ready and the config load is done;
  // retry is asserted out of reset so no target access slips in early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retry_r <= 1'b1;
    end else begin
      retry_r <= !(ctrl_r[`BIT_TGT_READY] && cfg_done_r);
    end
  end

  // outputs straight from their flops
  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign irq          = irq_r;
  assign target_retry = retry_r;

endmodule : pci_controller_status_flags

// file: hw/pci_ctl_status_pkg.sv
// types shared by the controller status bank
package pci_ctl_status_pkg;
  typedef logic [31:0] word_type;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_BUSY = 2'b01,
    WR_DONE = 2'b11
  } wr_state_type;
endpackage : pci_ctl_status_pkg

// file: hw/pci_ctl_status_regs.svh
// register offsets, field positions and reset values of the controller status bank
`ifndef PCI_CTL_STATUS_REGS_SVH
`define PCI_CTL_STATUS_REGS_SVH

`define STAT_OFFSET      16'hd174
`define MASK_OFFSET      16'hd178
`define CTRL_OFFSET      16'hd17c
`define BIT_WAKE         10
`define BIT_LONG_BURST   9
`define BIT_DEC_BURST    8
`define BIT_FIX_BURST    7
`define BIT_PARITY       5
`define BIT_SYSERR       4
`define BIT_BUS_ERR      3
`define BIT_WR_BUSY      1
`define BIT_CFG_DONE     0
`define BIT_TGT_READY    0
`define BIT_HOST_MODE    1
`define STICKY_MASK      32'h0000_07b8
`define CTRL_MASK        32'h0000_0003
`define ZERO_WORD        32'h0000_0000
`define CTRL_RESET       32'h0000_0000
`define MAX_BURST_DW     8'h08
`define SYNC_RESET       3'h0

`endif

// file: verif/pci_controller_status_flags_tb.sv
// self-checking bench of the controller status bank
`timescale 1ns/1ns
`include "pci_ctl_status_regs.svh"
module pci_controller_status_flags_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
  logic [15:0] paddr = '0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] lf = 32'h45b7_f139;
  pci_ctl_status_pkg::word_type pwdata = '0, prdata, rd;
  wire pready, pslverr, irq, target_retry, pme_n, perr_n, serr_n, dma_burst_valid;
  wire dma_burst_down, dma_burst_fixed, ibus_timeout, ibus_own_master;
  wire wr_start, wr_end, wr_error, cfg_load_end;
  wire [7:0] dma_burst_len;
  int num_errors = 0, n_tests = 0, k, exp, mask;
  int bits[9] = '{0, 'h200, 'h100, 'h80, 'h400, 'h20, 'h10, 0, 'h8};
  pci_controller_status_flags pci_controller_status_flags_i (.*);
  pci_far_side_model far_i (.*);
  always #20 pclk = ~pclk;
  ////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task stop_test;
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task chk(input string nm, input int e, input pci_ctl_status_pkg::word_type g);
    n_tests++;
    if (g !== 32'(e)) begin
      $display("[FAIL] %s expected %h got %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  // one apb transfer; hold until pready is seen at an edge
  task apb(input logic w, input logic [15:0] a, input int d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 32'(d)};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      num_errors++;
      stop_test();
    end
    rd = prdata;
    slv = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task st(input string nm);
    apb(0, `STAT_OFFSET, 0);
    chk(nm, exp, rd);
    chk("irq", {31'b0, |(exp & mask)}, {31'b0, irq});
  endtask : st
  ////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    exp = 0;
    mask = 0;
    st("status");
    apb(1, `CTRL_OFFSET, 3);
    chk("retry", 1, {31'b0, target_retry});
    far_i.pulse(2, 0);
    repeat (3) @(posedge pclk);
    chk("retry", 0, {31'b0, target_retry});
    exp = 1;
    st("done");
    lf = lfsr(lf);
    mask = lf & `STICKY_MASK;
    apb(1, `MASK_OFFSET, lf);
    apb(0, `MASK_OFFSET, 0);
    chk("mask", mask, rd);
    for (k = 0; k < 9; k++) begin
      lf = lfsr(lf);
      case (k)
        0, 1: far_i.burst(8 + k, 0, 0);
        2, 3: far_i.burst(lf[2:0] + 1, k == 2, k == 3);
        4, 5, 6: far_i.pin(k - 4);
        default: far_i.tmo(k == 8);
      endcase
      repeat (10) @(posedge pclk);
      exp = exp | bits[k];
      st("event");
      apb(1, `STAT_OFFSET, -1);
      exp = 1;
      st("cleared");
    end
    far_i.pulse(0, 1);
    exp = 3;
    st("busy");
    far_i.pulse(1, 0);
    k = 0;
    do begin
      apb(0, `STAT_OFFSET, 0);
      k++;
    end while (rd[1] !== 1'b0 && k < 20);
    if (k == 20) num_errors++;
    exp = 9;
    st("write error");
    apb(0, 16'hd180, 0);
    chk("unmapped", 1, {31'b0, slv});
    apb(1, `MASK_OFFSET, 0);
    mask = 0;
    st("masked");
    stop_test();
  end
endmodule : pci_controller_status_flags_tb

// file: verif/pci_far_side_model.sv
// far side: pci pins, dma burst reporter, internal bus, write tracker
`timescale 1ns/1ns
module pci_far_side_model (
  input  wire logic  pclk,
  output logic       pme_n,
  output logic       perr_n,
  output logic       serr_n,
  output logic       dma_burst_valid,
  output logic       dma_burst_down,
  output logic       dma_burst_fixed,
  output logic [7:0] dma_burst_len,
  output logic       ibus_timeout,
  output logic       ibus_own_master,
  output logic       wr_start,
  output logic       wr_end,
  output logic       wr_error,
  output logic       cfg_load_end
);
  // idle levels at time zero; pins are pulled up
  initial begin
    {pme_n, perr_n, serr_n} = 3'b111;
    {dma_burst_valid, dma_burst_len, dma_burst_down, dma_burst_fixed} = '0;
    {ibus_timeout, ibus_own_master, wr_start, wr_end, wr_error, cfg_load_end} = '0;
  end
  ////////////////////
  task pin(input int k);
    @(posedge pclk);
    {pme_n, perr_n, serr_n} <= ~(3'b100 >> k);
    repeat (6) @(posedge pclk);
    {pme_n, perr_n, serr_n} <= 3'b111;
  endtask : pin
  // qualifiers invert after valid so stale values never look good
  task burst(input logic [7:0] len, input logic dn, input logic fx);
    @(posedge pclk);
    {dma_burst_valid, dma_burst_len, dma_burst_down, dma_burst_fixed} <= {1'b1, len, dn, fx};
    @(posedge pclk);
    {dma_burst_valid, dma_burst_len, dma_burst_down, dma_burst_fixed} <= {1'b0, ~len, ~dn, ~fx};
  endtask : burst
  task tmo(input logic own);
    @(posedge pclk);
    {ibus_timeout, ibus_own_master} <= {1'b1, own};
    @(posedge pclk);
    {ibus_timeout, ibus_own_master} <= {1'b0, ~own};
  endtask : tmo
  // k: 0 write start, 1 write end, 2 config load end
  task pulse(input int k, input logic err);
    @(posedge pclk);
    {wr_start, wr_end, cfg_load_end} <= 3'b100 >> k;
    wr_error <= err;
    @(posedge pclk);
    {wr_start, wr_end, cfg_load_end} <= 3'b000;
  endtask : pulse
endmodule : pci_far_side_model

// file: verif/pci_status_chk.sv
// port assertions of the controller status bank
`timescale 1ns/1ns
`include "pci_ctl_status_regs.svh"
module pci_status_chk #(parameter int unsigned ADDR_W = 16) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              irq,
  input wire logic              wr_start,
  input wire logic              wr_end,
  input wire logic              cfg_load_end,
  input wire logic              target_retry
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] mask_r;
  logic        busy_r, done_r;
  wire acc = psel && penable;
  wire rd_st = acc && !pwrite && paddr == `STAT_OFFSET;
  wire mapped = paddr inside {`STAT_OFFSET, `MASK_OFFSET, `CTRL_OFFSET};
  ////////////////////
  // snooped mask, busy and done; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (acc && pwrite && paddr == `MASK_OFFSET) mask_r <= pwdata & `STICKY_MASK;
      busy_r <= wr_start | (busy_r & ~wr_end);
      done_r <= done_r | cfg_load_end;
    end
  end
  ////////////////////
  sequence s_setup; psel && !penable; endsequence
  sequence s_acc; psel && penable; endsequence
  property p_rdy; s_setup ##1 s_acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_err; (s_setup and !mapped) ##1 s_acc |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slverr");
  property p_wz; acc && pwrite |-> prdata == '0; endproperty
  a_wz: assert property (p_wz) else $error("rdata on write");
  property p_rsv; rd_st |-> (prdata & 32'hffff_f844) == '0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_busy; rd_st |-> prdata[1] == $past(busy_r); endproperty
  a_busy: assert property (p_busy) else $error("busy bit wrong");
  property p_done; rd_st |-> prdata[0] == $past(done_r); endproperty
  a_done: assert property (p_done) else $error("done bit wrong");
  property p_rty; !done_r |-> target_retry; endproperty
  a_rty: assert property (p_rty) else $error("retry dropped early");
  property p_irq; mask_r == '0 && $past(mask_r) == '0 |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq while masked");
endmodule : pci_status_chk
bind pci_controller_status_flags pci_status_chk #(.ADDR_W(ADDR_W)) chk_i (.*);
